//--- common/drive_status_pkg.sv
/*
 * Shared constants and types for the drive status output selector:
 * register offsets, reset values, selector codes, timing and the
 * packed set of internal status flags.
 * Assumes a single 250 MHz control clock and an APB register port.
 */
package drive_status_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_10MS_NS = 10_000_000;
    localparam int TICK_10MS_CYCLES = TICK_10MS_NS / CLK_PERIOD_NS;
    localparam logic [6:0] TICKS_PER_SECOND = 7'h64;

    // register byte offsets
    localparam logic [7:0] ADDR_SEL_LO = 8'h00;
    localparam logic [7:0] ADDR_SEL_HI = 8'h04;
    localparam logic [7:0] ADDR_COMM = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_OVERHEAT = 8'h10;
    localparam logic [7:0] ADDR_LOAD = 8'h14;
    localparam logic [7:0] ADDR_CAP_LIMIT = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_LIFE = 8'h20;
    localparam logic [7:0] ADDR_LIFE_COUNT = 8'h24;

    // selector codes
    localparam logic [7:0] CODE_NET = 8'h20;
    localparam logic [7:0] CODE_CAP = 8'h27;
    localparam logic [7:0] CODE_FAN = 8'h28;
    localparam logic [7:0] CODE_RUN = 8'h29;
    localparam logic [7:0] CODE_OHF = 8'h2A;
    localparam logic [7:0] CODE_LOAD = 8'h2B;
    localparam logic [7:0] CODE_READY = 8'h32;
    localparam logic [7:0] CODE_FWD = 8'h33;
    localparam logic [7:0] CODE_REV = 8'h34;

    // reset values and limits
    localparam logic [7:0] TERM_SEL_RESET = 8'h00;
    localparam logic [7:0] RELAY_SEL_RESET = 8'h05;
    localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
    localparam logic [15:0] TIMEOUT_MAX = 16'h270F;
    localparam logic [1:0] FAN_CTRL_RESET = 2'h0;
    localparam logic [1:0] FAN_CTRL_STOP_OK = 2'h1;
    localparam logic [7:0] OVERHEAT_RESET = 8'h78;
    localparam logic [7:0] OVERHEAT_MAX = 8'hC8;
    localparam logic LOAD_MODE_RESET = 1'b1;
    localparam int LOAD_MAX_SMALL_PCT = 200;
    localparam int LOAD_MAX_LARGE_PCT = 180;
    localparam logic [31:0] CAP_LIMIT_RESET = 32'h0100_0000;

    // fan drop at 75% of nominal: speed*4 <= nominal*3
    localparam logic [17:0] FAN_DROP_NUM = 18'h00003;
    localparam logic [17:0] FAN_DROP_DEN = 18'h00004;

    // capacitor ageing doubles each 10 degrees over these steps
    localparam logic [7:0] AGE_STEP_1 = 8'h28;
    localparam logic [7:0] AGE_STEP_2 = 8'h32;
    localparam logic [7:0] AGE_STEP_3 = 8'h3C;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_FWD = 2'b01,
        RUN_REV = 2'b10,
        RUN_BLOCK = 2'b11
    } run_state_t;

    typedef struct packed {
        logic capacitor_life_warning;
        logic network_timeout_flag;
        logic fan_speed_drop_flag;
        logic run_command_present;
        logic heatsink_overheat_flag;
        logic light_load_flag;
        logic operation_ready_flag;
        logic forward_running_flag;
        logic reverse_running_flag;
    } status_flags_t;

    // condition named by a selector code; unknown codes drive off
    function automatic logic pick_flag(input logic [7:0] code,
                                       input status_flags_t f);
        logic r;
        r = 1'b0;
        case (code)
            CODE_NET: r = f.network_timeout_flag;
            CODE_CAP: r = f.capacitor_life_warning;
            CODE_FAN: r = f.fan_speed_drop_flag;
            CODE_RUN: r = f.run_command_present;
            CODE_OHF: r = f.heatsink_overheat_flag;
            CODE_LOAD: r = f.light_load_flag;
            CODE_READY: r = f.operation_ready_flag;
            CODE_FWD: r = f.forward_running_flag;
            CODE_REV: r = f.reverse_running_flag;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

endpackage

//--- src/drive_status_output_select.sv
/*
 * Status generation and output selection for five open-collector
 * terminals and one relay of a motor drive, with an APB register port.
 * Assumes the drive core supplies its measurements on CLK_I; only the
 * forward and reverse run pins arrive asynchronously.
 */
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module drive_status_output_select
    import drive_status_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_10MS_CYCLES,
    parameter logic [15:0] RATED_CURRENT = 16'h0064,
    parameter logic [15:0] FAN_NOMINAL = 16'h0BB8,
    parameter logic LARGE_RATING = 1'b0
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic FORWARD_RUN_INPUT_I,
    input wire logic REVERSE_RUN_INPUT_I,
    input wire logic COMM_DATA_RECEIVED_I,
    input wire logic [15:0] FAN_SPEED_I,
    input wire logic FAN_STOPPED_I,
    input wire logic [7:0] FIN_TEMP_I,
    input wire logic [15:0] OUTPUT_CURRENT_I,
    input wire logic AT_CONST_SPEED_I,
    input wire logic MOTOR_RUNNING_I,
    input wire logic MOTOR_REVERSE_I,
    input wire logic SUPPLY_OK_I,
    input wire logic TRIP_I,
    output logic [4:0] TERM_O,
    output logic RELAY_CONTACT_A_O,
    output logic RELAY_CONTACT_B_O,
    output logic RUN_FWD_O,
    output logic RUN_REV_O,
    output logic DRIVE_STOP_O
);

    localparam int LOAD_MAX_INT = LARGE_RATING ?
        (int'(RATED_CURRENT) * LOAD_MAX_LARGE_PCT) / 100 :
        (int'(RATED_CURRENT) * LOAD_MAX_SMALL_PCT) / 100;
    localparam logic [15:0] LOAD_MAX = 16'(LOAD_MAX_INT);

    logic [7:0] sel [6];
    logic [15:0] comm_timeout_setting;
    logic modbus_rtu;
    logic [1:0] fan_control_setting;
    logic run_source_select;
    logic sw_fwd;
    logic sw_rev;
    logic [7:0] overheat_level_setting;
    logic [15:0] light_load_level_setting;
    logic light_load_mode_setting;
    logic [31:0] cap_limit;
    logic [31:0] life_acc;
    logic [21:0] tick_cnt;
    logic tick;
    logic [6:0] sec_cnt;
    logic [15:0] idle_ticks;
    logic net_flag;
    logic [2:0] fw_sync;
    logic [2:0] rv_sync;
    logic fw_level;
    logic rv_level;
    run_state_t run_state;
    run_state_t next_run_state;
    status_flags_t flags;
    logic [5:0] out_q;
    logic cmd_fw;
    logic cmd_rv;
    logic conflict;
    logic net_set;
    logic [31:0] rd_data;
    logic rd_ok;
    logic wr_en;
    logic [31:0] wr_word;

    // byte-lane merge for APB strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign wr_en = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

    // read word of the addressed register, before the write merge
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        case (PADDR_I)
            ADDR_SEL_LO: rd_data = {sel[3], sel[2], sel[1], sel[0]};
            ADDR_SEL_HI: rd_data = {16'h0000, sel[5], sel[4]};
            ADDR_COMM: rd_data = {15'h0000, modbus_rtu,
                                  comm_timeout_setting};
            ADDR_CTRL: rd_data = {27'h0000000, sw_rev, sw_fwd,
                                  run_source_select, fan_control_setting};
            ADDR_OVERHEAT: rd_data = {24'h000000, overheat_level_setting};
            ADDR_LOAD: rd_data = {15'h0000, light_load_mode_setting,
                                  light_load_level_setting};
            ADDR_CAP_LIMIT: rd_data = cap_limit;
            ADDR_STATUS: rd_data = {15'h0000, run_state, out_q, flags};
            ADDR_LIFE: rd_data = {30'h00000000,
                                  flags.fan_speed_drop_flag,
                                  flags.capacitor_life_warning};
            ADDR_LIFE_COUNT: rd_data = life_acc;
            default: rd_ok = 1'b0;
        endcase
    end

    assign wr_word = merge(rd_data, PWDATA_I, PSTRB_I);

    // apb answer: ready in the first access cycle, data caught at setup
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PREADY_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I & ~PENABLE_I;
            if (PSEL_I & ~PENABLE_I) begin
                PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_data;
                PSLVERR_O <= ~rd_ok;
            end
        end
    end

    // selector registers; relay starts on code 05
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < 5; i++) begin
                sel[i] <= TERM_SEL_RESET;
            end
            sel[5] <= RELAY_SEL_RESET;
        end else if (wr_en && PADDR_I == ADDR_SEL_LO) begin
            for (int i = 0; i < 4; i++) begin
                sel[i] <= wr_word[i*8 +: 8];
            end
        end else if (wr_en && PADDR_I == ADDR_SEL_HI) begin
            sel[4] <= wr_word[7:0];
            sel[5] <= wr_word[15:8];
        end
    end

    // settings; out-of-range values clamp to the top of their range
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            comm_timeout_setting <= TIMEOUT_RESET;
            modbus_rtu <= 1'b0;
            fan_control_setting <= FAN_CTRL_RESET;
            run_source_select <= 1'b0;
            sw_fwd <= 1'b0;
            sw_rev <= 1'b0;
            overheat_level_setting <= OVERHEAT_RESET;
            light_load_level_setting <= RATED_CURRENT;
            light_load_mode_setting <= LOAD_MODE_RESET;
            cap_limit <= CAP_LIMIT_RESET;
        end else if (wr_en) begin
            case (PADDR_I)
                ADDR_COMM: begin
                    comm_timeout_setting <= (wr_word[15:0] > TIMEOUT_MAX) ?
                        TIMEOUT_MAX : wr_word[15:0];
                    modbus_rtu <= wr_word[16];
                end
                ADDR_CTRL: begin
                    fan_control_setting <= wr_word[1:0];
                    run_source_select <= wr_word[2];
                    sw_fwd <= wr_word[3];
                    sw_rev <= wr_word[4];
                end
                ADDR_OVERHEAT: begin
                    overheat_level_setting <=
                        (wr_word[7:0] > OVERHEAT_MAX) ?
                        OVERHEAT_MAX : wr_word[7:0];
                end
                ADDR_LOAD: begin
                    light_load_level_setting <=
                        (wr_word[15:0] > LOAD_MAX) ?
                        LOAD_MAX : wr_word[15:0];
                    light_load_mode_setting <= wr_word[16];
                end
                ADDR_CAP_LIMIT: cap_limit <= wr_word;
                default: cap_limit <= cap_limit;
            endcase
        end
    end

    // 10 ms time base shared by the timeout and the life estimate
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tick_cnt <= 22'h000000;
            tick <= 1'b0;
        end else if (tick_cnt == 22'(TICK_CYCLES - 1)) begin
            tick_cnt <= 22'h000000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 22'h000001;
            tick <= 1'b0;
        end
    end

    // timeout is an event at the tick that reaches the setting, so the next
    // data releases the flag unless a set falls in the same cycle; zero disables it, and a setting lowered
    // below the running count waits for data first
    assign net_set = modbus_rtu && tick &&
                     comm_timeout_setting != TIMEOUT_RESET &&
                     idle_ticks == comm_timeout_setting - 16'h0001;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            idle_ticks <= 16'h0000;
        end else if (COMM_DATA_RECEIVED_I) begin
            idle_ticks <= 16'h0000;
        end else if (tick && idle_ticks != 16'hFFFF) begin
            idle_ticks <= idle_ticks + 16'h0001;
        end
    end

    // held until the next data; a set in the same cycle wins
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            net_flag <= 1'b0;
        end else if (!modbus_rtu) begin
            net_flag <= 1'b0;
        end else if (net_set) begin
            net_flag <= 1'b1;
        end else if (COMM_DATA_RECEIVED_I) begin
            net_flag <= 1'b0;
        end
    end

    // powered-on seconds weighted by temperature; saturates
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sec_cnt <= 7'h00;
            life_acc <= 32'h0000_0000;
        end else if (tick) begin
            if (sec_cnt == TICKS_PER_SECOND - 7'h01) begin
                sec_cnt <= 7'h00;
                if (life_acc < 32'hFFFF_FFF0) begin
                    if (FIN_TEMP_I >= AGE_STEP_3) begin
                        life_acc <= life_acc + 32'h0000_0008;
                    end else if (FIN_TEMP_I >= AGE_STEP_2) begin
                        life_acc <= life_acc + 32'h0000_0004;
                    end else if (FIN_TEMP_I >= AGE_STEP_1) begin
                        life_acc <= life_acc + 32'h0000_0002;
                    end else begin
                        life_acc <= life_acc + 32'h0000_0001;
                    end
                end
            end else begin
                sec_cnt <= sec_cnt + 7'h01;
            end
        end
    end

    // run pins: three flops, a change counts once stages two and three agree
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fw_sync <= 3'h0;
            rv_sync <= 3'h0;
            fw_level <= 1'b0;
            rv_level <= 1'b0;
        end else begin
            fw_sync <= {fw_sync[1:0], FORWARD_RUN_INPUT_I};
            rv_sync <= {rv_sync[1:0], REVERSE_RUN_INPUT_I};
            if (fw_sync[1] == fw_sync[2]) begin
                fw_level <= fw_sync[2];
            end
            if (rv_sync[1] == rv_sync[2]) begin
                rv_level <= rv_sync[2];
            end
        end
    end

    assign cmd_fw = run_source_select ? sw_fwd : fw_level;
    assign cmd_rv = run_source_select ? sw_rev : rv_level;
    assign conflict = cmd_fw & cmd_rv;

    // run acceptance; a refused command must be released before retry
    always_comb begin
        next_run_state = run_state;
        case (run_state)
            RUN_IDLE: begin
                if (conflict || ((cmd_fw || cmd_rv) &&
                                 !flags.operation_ready_flag)) begin
                    next_run_state = RUN_BLOCK;
                end else if (cmd_fw) begin
                    next_run_state = RUN_FWD;
                end else if (cmd_rv) begin
                    next_run_state = RUN_REV;
                end
            end
            RUN_FWD: begin
                if (conflict || !flags.operation_ready_flag) begin
                    next_run_state = RUN_BLOCK;
                end else if (!cmd_fw) begin
                    next_run_state = RUN_IDLE;
                end
            end
            RUN_REV: begin
                if (conflict || !flags.operation_ready_flag) begin
                    next_run_state = RUN_BLOCK;
                end else if (!cmd_rv) begin
                    next_run_state = RUN_IDLE;
                end
            end
            RUN_BLOCK: begin
                if (!cmd_fw && !cmd_rv) begin
                    next_run_state = RUN_IDLE;
                end
            end
            default: next_run_state = RUN_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            run_state <= RUN_IDLE;
            RUN_FWD_O <= 1'b0;
            RUN_REV_O <= 1'b0;
            DRIVE_STOP_O <= 1'b0;
        end else begin
            run_state <= next_run_state;
            RUN_FWD_O <= next_run_state == RUN_FWD;
            RUN_REV_O <= next_run_state == RUN_REV;
            DRIVE_STOP_O <= conflict;
        end
    end

    // status conditions, combinational so terminals lag by one flop only
    always_comb begin
        flags.capacitor_life_warning = life_acc >= cap_limit;
        flags.network_timeout_flag = net_flag;
        flags.fan_speed_drop_flag =
            ({2'b00, FAN_SPEED_I} * FAN_DROP_DEN <=
             {2'b00, FAN_NOMINAL} * FAN_DROP_NUM) &&
            !(fan_control_setting == FAN_CTRL_STOP_OK &&
              FAN_STOPPED_I);
        flags.run_command_present = fw_level | rv_level |
                                    sw_fwd | sw_rev;
        flags.heatsink_overheat_flag =
            FIN_TEMP_I > overheat_level_setting;
        flags.light_load_flag = MOTOR_RUNNING_I &&
            OUTPUT_CURRENT_I < light_load_level_setting &&
            (!light_load_mode_setting || AT_CONST_SPEED_I);
        flags.operation_ready_flag = SUPPLY_OK_I & ~TRIP_I;
        flags.forward_running_flag =
            MOTOR_RUNNING_I & ~MOTOR_REVERSE_I;
        flags.reverse_running_flag =
            MOTOR_RUNNING_I & MOTOR_REVERSE_I;
    end

    // one selector stage per terminal, no delay beyond the output flop
    for (genvar g = 0; g < 6; g++) begin : g_term
        always_ff @(posedge CLK_I) begin
            if (RST_I) begin
                out_q[g] <= 1'b0;
            end else begin
                out_q[g] <= pick_flag(sel[g], flags);
            end
        end
    end

    // relay break contact needs its own flop to stay glitch free
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RELAY_CONTACT_B_O <= 1'b1;
        end else begin
            RELAY_CONTACT_B_O <= ~pick_flag(sel[5], flags);
        end
    end

    assign TERM_O = out_q[4:0];
    assign RELAY_CONTACT_A_O = out_q[5];

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_ohf_selected;
        sel[0] == CODE_OHF && FIN_TEMP_I > overheat_level_setting;
    endsequence

    sequence s_refused_start;
        run_state == RUN_IDLE && cmd_fw && !cmd_rv &&
        !flags.operation_ready_flag;
    endsequence

    AST_RELAY_DEFAULT: assert property ($fell(RST_I) |->
        sel[5] == RELAY_SEL_RESET) else $error("relay selector not 05");
    AST_NET_MODBUS_ONLY: assert property (!modbus_rtu |=>
        !flags.network_timeout_flag) else $error("net flag w/o modbus");
    AST_NET_RELEASE: assert property (
        COMM_DATA_RECEIVED_I && !net_set |=> !net_flag)
        else $error("net flag kept after data");
    AST_FAN_SUPPRESS: assert property (
        fan_control_setting == FAN_CTRL_STOP_OK && FAN_STOPPED_I |->
        !flags.fan_speed_drop_flag) else $error("fan flag while stopped");
    AST_OHF_TERM: assert property (s_ohf_selected |=> TERM_O[0])
        else $error("terminal 11 missed overheat");
    AST_OHF_CLAMP: assert property (
        overheat_level_setting <= OVERHEAT_MAX) else $error("level over 200");
    AST_LOAD_MODE: assert property (
        light_load_mode_setting && !AT_CONST_SPEED_I |->
        !flags.light_load_flag) else $error("light load off const");
    AST_NOT_READY: assert property (s_refused_start |=>
        !RUN_FWD_O ##1 !RUN_FWD_O)
        else $error("start while not ready");
    AST_CONFLICT: assert property (conflict |=>
        DRIVE_STOP_O && !RUN_FWD_O && !RUN_REV_O)
        else $error("conflict did not stop");
    AST_RUN_PRESENT: assert property ((fw_level || rv_level) |->
        flags.run_command_present) else $error("run command not shown");
    AST_DIRECTION: assert property (
        !MOTOR_RUNNING_I || MOTOR_REVERSE_I |->
        !flags.forward_running_flag) else $error("forward flag wrong");
    AST_REVERSE: assert property (
        !MOTOR_RUNNING_I || !MOTOR_REVERSE_I |->
        !flags.reverse_running_flag) else $error("reverse flag wrong");
    AST_LIFE_MON: assert property (
        PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == ADDR_LIFE |=>
        PRDATA_O[1:0] == $past({flags.fan_speed_drop_flag,
                                flags.capacitor_life_warning}))
        else $error("life monitor mismatch");

endmodule // drive_status_output_select

//--- verif/machine_ctrl_model.sv
/*
 external machine controller model that drives the two run pins.
 assumes requests change right after a rising clock edge.
*/
`timescale 1ns/1ns
module machine_ctrl_model (
    input wire logic clk_i,
    input wire logic fwd_req_i,
    input wire logic rev_req_i,
    input wire logic both_ok_i,
    output logic fwd_o,
    output logic rev_o
);
    // both pins together only when a scenario asks for the conflict
    always_ff @(posedge clk_i) begin
        fwd_o <= fwd_req_i;
        rev_o <= rev_req_i & (both_ok_i | ~fwd_req_i);
    end
endmodule // machine_ctrl_model

//--- verif/drive_status_output_select_tb_top.sv
/*
 self-checking bench: registers over apb, status terminals, relay, run.
 assumes zero-wait apb answers and the design package constants.
*/
`timescale 1ns/1ns
module drive_status_output_select_tb_top;
    import drive_status_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, err;
    logic [7:0] pa = 8'h00, temp = 8'h00;
    logic [31:0] pwd = 32'h0, rd, prdata;
    logic [15:0] cur = 16'h0000, fan = 16'h0BB8;
    logic comm = 0, fstop = 0;
    logic cst = 0, mrun = 0, mrev = 0, sup = 0, trip = 0;
    logic fq = 0, rq = 0, both = 0, fpin, rpin;
    logic pready, pslverr, ra, rb, rfwd, rrev, dstop;
    logic [4:0] term;
    int miscompares = 0, n_checks = 0;
    drive_status_output_select #(.TICK_CYCLES(10)) dut (.CLK_I(clk),
        .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw),
        .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(4'hF), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr),
        .FORWARD_RUN_INPUT_I(fpin), .REVERSE_RUN_INPUT_I(rpin),
        .COMM_DATA_RECEIVED_I(comm), .FAN_SPEED_I(fan),
        .FAN_STOPPED_I(fstop), .FIN_TEMP_I(temp), .OUTPUT_CURRENT_I(cur),
        .AT_CONST_SPEED_I(cst), .MOTOR_RUNNING_I(mrun),
        .MOTOR_REVERSE_I(mrev), .SUPPLY_OK_I(sup), .TRIP_I(trip),
        .TERM_O(term), .RELAY_CONTACT_A_O(ra), .RELAY_CONTACT_B_O(rb),
        .RUN_FWD_O(rfwd), .RUN_REV_O(rrev), .DRIVE_STOP_O(dstop));
    machine_ctrl_model partner (.clk_i(clk), .fwd_req_i(fq),
        .rev_req_i(rq), .both_ok_i(both), .fwd_o(fpin), .rev_o(rpin));
    // free-running 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one-cycle received-data strobe
    task automatic rx_pulse();
        comm <= 1;
        tick(1);
        comm <= 0;
    endtask
    task automatic t_regs();
        chk({31'h0, rb}, 32'h1);
        apb(0, ADDR_SEL_HI, 0);
        chk(rd[15:8], 8'h05);
        apb(0, ADDR_OVERHEAT, 0);
        chk(rd, 32'h78);
        apb(0, ADDR_LOAD, 0);
        chk(rd[16:0], 17'h10064);
        apb(0, 8'h3C, 0);
        chk({31'h0, err}, 32'h1);
        apb(1, ADDR_SEL_LO, {CODE_FWD, CODE_READY, CODE_LOAD, CODE_OHF});
        apb(1, ADDR_SEL_HI, {16'h0, CODE_RUN, CODE_REV});
        apb(0, ADDR_SEL_LO, 0);
        chk(rd, {CODE_FWD, CODE_READY, CODE_LOAD, CODE_OHF});
        $display("test regs done");
    endtask
    task automatic t_heat_load();
        temp <= 8'h79;
        tick(3);
        chk(term[0], 1);
        temp <= 8'h78;
        tick(3);
        chk(term[0], 0);
        cur <= 16'h0063;
        mrun <= 1;
        tick(3);
        chk(term[1], 0);
        cst <= 1;
        tick(3);
        chk(term[1], 1);
        cur <= 16'h0064;
        tick(3);
        chk(term[1], 0);
        $display("test heat and load done");
    endtask
    task automatic t_run();
        trip <= 1;
        sup <= 1;
        fq <= 1;
        tick(8);
        chk(term[2], 0);
        chk(rfwd, 0);
        fq <= 0;
        trip <= 0;
        tick(8);
        chk(term[2], 1);
        fq <= 1;
        tick(8);
        chk(rfwd, 1);
        chk({ra, rb}, 2'b10);
        chk(term[4:3], 2'b01);
        mrev <= 1;
        tick(3);
        chk(term[4:3], 2'b10);
        both <= 1;
        rq <= 1;
        tick(8);
        chk(dstop, 1);
        chk({rfwd, rrev}, 2'b00);
        fq <= 0;
        rq <= 0;
        mrun <= 0;
        tick(8);
        chk({ra, term[4:3]}, 3'b000);
        $display("test run done");
    endtask
    // net timeout, fan, capacitor life and a register-sourced run
    task automatic t_status();
        apb(1, ADDR_SEL_LO, {CODE_CAP, CODE_FAN, CODE_NET, CODE_OHF});
        apb(1, ADDR_CAP_LIMIT, 32'h8);
        tick(3);
        chk(term[3], 0);
        apb(1, ADDR_COMM, 32'hFFFF);
        apb(0, ADDR_COMM, 0);
        chk(rd, 32'h270F);
        apb(1, ADDR_COMM, 32'h2);
        rx_pulse();
        tick(30);
        chk(term[1], 0);
        apb(1, ADDR_COMM, 32'h1_0002);
        rx_pulse();
        tick(30);
        chk(term[1], 1);
        rx_pulse();
        tick(3);
        chk(term[1], 0);
        fan <= 16'h08CB;
        tick(3);
        chk(term[2], 0);
        fan <= 16'h08CA;
        tick(3);
        chk(term[2], 1);
        apb(0, ADDR_LIFE, 0);
        chk(rd, 32'h2);
        fstop <= 1;
        tick(3);
        chk(term[2], 1);
        apb(1, ADDR_CTRL, 32'h15);
        tick(3);
        chk(term[2], 0);
        chk(ra, 1);
        chk(rrev, 1);
        apb(1, ADDR_CTRL, 32'h1D);
        tick(3);
        chk({dstop, rrev}, 2'b10);
        apb(1, ADDR_CTRL, 32'h1);
        tick(1000);
        chk(term[3], 1);
        apb(0, ADDR_LIFE, 0);
        chk(rd, 32'h1);
        $display("test status done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        tick(8);
        rst <= 0;
        t_regs();
        t_heat_load();
        t_run();
        t_status();
        conclude();
    end
    // watchdog far beyond the some 1,200 cycles the tests take
    initial begin
        #40000;
        miscompares++;
        conclude();
    end
endmodule // drive_status_output_select_tb_top
